//--- hdl/sps_top.sv
// Serial port with master and slave modes behind an AHB-Lite slave
//
// Chosen here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
module sps_top
    import sps_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic gie_i,
    input wire logic irq_ack_i,
    output logic irq_o,
    output logic wake_o,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe,
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe,
    input wire logic ss_i,
    output logic ss_o,
    output logic ss_oe
);
    sps_state_t s;
    sps_state_t n;
    logic hit;
    logic lead;
    logic trail;
    logic done_evt;
    logic fault;
    logic wr_data;
    logic xfer;
    logic en;
    logic mst;
    logic clock_idle_level;
    logic clock_edge_phase;
    logic ord;
    logic [6:0] half;
    logic [7:0] fin;

    // Bit presented on the serial output for the current order
    function automatic logic out_bit(input logic [7:0] v, input logic lsb);
        out_bit = lsb ? v[0] : v[7];
    endfunction : out_bit

    // Shift one received bit in at the far end from the output bit
    function automatic logic [7:0] shin(input logic [7:0] v, input logic b, input logic lsb);
        shin = lsb ? {b, v[7:1]} : {v[6:0], b};
    endfunction : shin

    // All next-state logic; clears come first so that later sets win
    always_comb begin
        n = s;
        en = s.ctrl[SPS_C_EN];
        mst = s.ctrl[SPS_C_MST]; // [R19]
        clock_idle_level = s.ctrl[SPS_C_POL];
        clock_edge_phase = s.ctrl[SPS_C_PHA];
        ord = s.ctrl[SPS_C_ORD];
        half = SPS_SCK_DIV[s.ctrl[1:0]][7:1]; // [R23]
        hit = hsel && hready && htrans[1];
        lead = 1'b0;
        trail = 1'b0;
        done_evt = 1'b0;
        fin = s.sh;
        xfer = (s.mode == SPS_MSHIFT) || ((s.mode == SPS_SSHIFT) && (s.cnt != 4'h0));
        wr_data = s.ph_wr && (s.ph_idx == SPS_IDX_DATA);
        fault = en && mst && !s.pins[SPS_P_SS] && !ss_i; // [R12]

        // Vector taken clears the done flag in hardware
        if (irq_ack_i) begin
            n.done = 1'b0; // [R25]
        end
        // Address phase: status-then-access clear sequences and read data
        if (hit) begin
            if (s.arm_done) begin
                n.done = 1'b0; // [R25]
            end
            if (s.arm_write_collision_flag && (haddr[3:2] == SPS_IDX_DATA)) begin
                n.write_collision_flag = 1'b0; // [R24]
            end
            n.arm_done = !hwrite && (haddr[3:2] == SPS_IDX_STAT) && s.done;
            n.arm_write_collision_flag = !hwrite && (haddr[3:2] == SPS_IDX_STAT) && s.write_collision_flag;
            n.hrdata = 32'h00000000;
            if (!hwrite && (haddr[31:4] == SPS_ADDR_HI)) begin
                unique case (haddr[3:2])
                    SPS_IDX_CTRL: n.hrdata[7:0] = s.ctrl;
                    SPS_IDX_STAT: begin
                        n.hrdata[SPS_S_DONE] = s.done;
                        n.hrdata[SPS_S_WRITE_COLLISION_FLAG] = s.write_collision_flag;
                    end
                    SPS_IDX_DATA: n.hrdata[7:0] = s.rx; // [R7]
                    SPS_IDX_PINS: n.hrdata[7:0] = s.pins;
                endcase
            end
        end
        n.ph_wr = hit && hwrite && (haddr[31:4] == SPS_ADDR_HI);
        n.ph_idx = haddr[3:2];

        // Clock source: own divider as master, pin edges as slave
        n.sck_prev = sck_i;
        unique case (s.mode)
            SPS_IDLE: begin
                if (en && !mst && !ss_i) begin
                    n.mode = SPS_SSHIFT; // [R4] [R16]
                    n.cnt = 4'h0;
                end
            end
            SPS_MSHIFT: begin
                if (!en || !mst) begin
                    n.mode = SPS_IDLE;
                    n.cnt = 4'h0;
                end else if (s.div == 7'(half - 7'h01)) begin
                    n.div = 7'h00;
                    n.sck_m = ~s.sck_m; // [R9]
                    lead = (s.sck_m == clock_idle_level);
                    trail = (s.sck_m != clock_idle_level);
                end else begin
                    n.div = 7'(s.div + 7'h01);
                end
            end
            SPS_SSHIFT: begin
                if (!en || mst || ss_i) begin
                    // Partial bytes are dropped; the shift count restarts
                    n.mode = SPS_IDLE; // [R17]
                    n.cnt = 4'h0;
                end else begin
                    lead = (sck_i != clock_idle_level) && (s.sck_prev == clock_idle_level); // [R18]
                    trail = (sck_i == clock_idle_level) && (s.sck_prev != clock_idle_level);
                end
            end
        endcase

        // Sample and change edges follow the phase bit
        if ((lead && !clock_edge_phase) || (trail && clock_edge_phase)) begin
            n.rxbit = (s.mode == SPS_MSHIFT) ? miso_i : mosi_i; // [R5] [R27]
            n.cnt = 4'(s.cnt + 4'h1);
        end
        if ((trail && !clock_edge_phase) || (lead && clock_edge_phase && (s.cnt != 4'h0))) begin
            n.sh = shin(s.sh, s.rxbit, ord); // [R26] [R27]
        end
        // The eighth trailing edge ends the byte in every mode
        if (trail && (n.cnt == SPS_BITS)) begin
            fin = clock_edge_phase ? shin(s.sh, n.rxbit, ord) : shin(s.sh, s.rxbit, ord);
            done_evt = 1'b1;
            n.sh = fin;
            n.rx = fin; // [R7]
            n.cnt = 4'h0;
            n.done = 1'b1; // [R2]
            if (s.mode == SPS_MSHIFT) begin
                n.mode = SPS_IDLE; // [R2]
                n.sck_m = clock_idle_level;
            end
        end

        // Data phase writes land here
        if (s.ph_wr) begin
            unique case (s.ph_idx)
                SPS_IDX_CTRL: n.ctrl = hwdata[7:0]; // [R20] [R14]
                SPS_IDX_PINS: n.pins = hwdata[7:0];
                SPS_IDX_DATA: begin
                    if (xfer) begin
                        n.write_collision_flag = 1'b1; // [R6] [R24]
                    end else begin
                        n.sh = hwdata[7:0];
                        n.cnt = 4'h0;
                        if (en && mst) begin
                            n.mode = SPS_MSHIFT; // [R1]
                            n.div = 7'h00;
                            n.sck_m = clock_idle_level;
                        end
                    end
                end
                SPS_IDX_STAT: n.ph_wr = 1'b0;
            endcase
            n.ph_wr = hit && hwrite && (haddr[31:4] == SPS_ADDR_HI);
        end

        // Mode fault: another master selected us; only software restores master
        if (fault) begin
            n.ctrl[SPS_C_MST] = 1'b0; // [R12] [R14]
            n.done = 1'b1; // [R13]
            n.mode = SPS_IDLE;
            n.cnt = 4'h0;
        end

        n.irq = n.done && n.ctrl[SPS_C_IE] && gie_i; // [R3] [R13]
        n.wake = done_evt && (s.mode == SPS_SSHIFT); // [R21]
        n.hready = 1'b1;
        n.hresp = 1'b0;

        // Pin drive from the next state so pins match the state flops
        n.mosi_o = 1'b0;
        n.miso_o = 1'b0;
        n.sck_o = 1'b0;
        n.ss_o = n.pins[SPS_P_SSLVL];
        n.mosi_oe = n.pins[SPS_P_MOSI];
        n.miso_oe = n.pins[SPS_P_MISO];
        n.sck_oe = n.pins[SPS_P_SCK];
        n.ss_oe = n.pins[SPS_P_SS];
        if (n.ctrl[SPS_C_EN] && n.ctrl[SPS_C_MST]) begin
            n.mosi_o = out_bit(n.sh, n.ctrl[SPS_C_ORD]);
            n.sck_o = (n.mode == SPS_MSHIFT) ? n.sck_m : n.ctrl[SPS_C_POL]; // [R9] [R22]
            n.miso_oe = 1'b0; // [R8] [R10]
        end else if (n.ctrl[SPS_C_EN]) begin
            // Slave: everything is an input unless selected
            n.mosi_oe = 1'b0; // [R8] [R16]
            n.sck_oe = 1'b0;
            n.ss_oe = 1'b0;
            n.miso_oe = n.pins[SPS_P_MISO] && (n.mode == SPS_SSHIFT);
            n.miso_o = out_bit(n.sh, n.ctrl[SPS_C_ORD]); // [R5]
        end
    end

    // State register; bus is ready from reset with zero wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
            s.ctrl <= SPS_CTRL_RST; // [R20]
            s.pins <= SPS_PINS_RST;
            s.mode <= SPS_IDLE;
            s.hready <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign hrdata = s.hrdata;
    assign hreadyout = s.hready;
    assign hresp = s.hresp;
    assign irq_o = s.irq;
    assign wake_o = s.wake;
    assign mosi_o = s.mosi_o;
    assign mosi_oe = s.mosi_oe;
    assign miso_o = s.miso_o;
    assign miso_oe = s.miso_oe;
    assign sck_o = s.sck_o;
    assign sck_oe = s.sck_oe;
    assign ss_o = s.ss_o;
    assign ss_oe = s.ss_oe;

    default clocking sps_cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence m_start;
        wr_data && !xfer && en && mst && !fault;
    endsequence
    sequence m_run;
        ((s.mode == SPS_MSHIFT) || !s.ctrl[SPS_C_MST] || !s.ctrl[SPS_C_EN])[*8];
    endsequence

    start_shift_a: assert property (m_start |=> s.mode == SPS_MSHIFT) // [R1]
        else $error("data write did not start master shift");
    byte_span_a: assert property (m_start |=> m_run) // [R2]
        else $error("master byte ended too early");
    done_stop_a: assert property (done_evt && s.mode == SPS_MSHIFT && !fault
        |=> s.mode == SPS_IDLE && s.done) // [R2]
        else $error("clock did not stop with done set");
    irq_out_a: assert property ($rose(s.done) && s.ctrl[SPS_C_IE] && $past(gie_i) |-> irq_o) // [R3]
        else $error("done with enable gave no interrupt");
    // A shift edge in the same cycle moves the register legally, so only quiet cycles count
    write_collision_flag_set_a: assert property (wr_data && xfer && !lead && !trail // [R24]
        |=> s.write_collision_flag && $stable(s.sh))
        else $error("write during transfer not refused");
    fault_slave_a: assert property (fault |=> !s.ctrl[SPS_C_MST] && s.done) // [R12]
        else $error("mode fault did not force slave");
    ss_reset_a: assert property (s.mode == SPS_SSHIFT && ss_i
        |=> s.mode == SPS_IDLE && s.cnt == 4'h0) // [R17]
        else $error("select high did not reset slave");
    slave_pins_a: assert property (s.ctrl[SPS_C_EN] && !s.ctrl[SPS_C_MST]
        |-> !mosi_oe && !sck_oe && !ss_oe) // [R16]
        else $error("slave drives an input pin");
    miso_in_a: assert property (s.ctrl[SPS_C_EN] && s.ctrl[SPS_C_MST] |-> !miso_oe) // [R8]
        else $error("master drives miso");
    sck_idle_a: assert property (s.ctrl[SPS_C_EN] && s.ctrl[SPS_C_MST]
        && s.mode != SPS_MSHIFT |-> sck_o == s.ctrl[SPS_C_POL]) // [R22]
        else $error("idle clock level wrong");
endmodule : sps_top

//--- hdl/sps_pkg.sv
// Constants and types shared by the serial port block
// What this block does
// [R1] Master data write starts clock, shifts out
// [R2] Stop clock after one byte, set done
// [R3] Done and enable request an interrupt
// [R4] Slave selected only while select low
// [R5] Both shift registers exchange bytes circularly
// [R6] Single transmit buffer, write during transfer refused
// [R7] Software reads received byte before next
// [R8] Enabled port overrides pin directions
// [R9] Clock pin drives as master, receives slave
// [R10] Master output select is plain output
// [R11] Master input select held high externally
// [R12] Select low as master forces slave
// [R13] Fault sets done, interrupts when enabled
// [R14] Stays slave until software sets master
// [R15] Handler checks master bit still set
// [R16] Slave select input; high means passive
// [R17] Select high resets slave, drops partial bytes
// [R18] Polarity and phase pick four modes
// [R19] Master bit one master, zero slave
// [R20] Control bits layout, read-write, reset zero
// [R21] Completion wakes device only as slave
// [R22] Polarity one idles clock high
// [R23] Rate bits divide clock by 4..128
// [R24] Data write mid-transfer sets collision flag
// [R25] Done cleared by vector or status sequence
// [R26] Order bit one LSB first, zero MSB
// [R27] Phase chooses sample and change edges
package sps_pkg;
    // Word indices of the registers, decoded from haddr[3:2]
    localparam logic [1:0] SPS_IDX_CTRL = 2'h0;
    localparam logic [1:0] SPS_IDX_STAT = 2'h1;
    localparam logic [1:0] SPS_IDX_DATA = 2'h2;
    localparam logic [1:0] SPS_IDX_PINS = 2'h3;
    localparam logic [27:0] SPS_ADDR_HI = 28'h0000000;
    // Control register fields
    localparam int SPS_C_IE = 7;
    localparam int SPS_C_EN = 6;
    localparam int SPS_C_ORD = 5;
    localparam int SPS_C_MST = 4;
    localparam int SPS_C_POL = 3;
    localparam int SPS_C_PHA = 2;
    // Status register fields
    localparam int SPS_S_DONE = 7;
    localparam int SPS_S_WRITE_COLLISION_FLAG = 6;
    // Pin control fields: directions and select output level
    localparam int SPS_P_MOSI = 0;
    localparam int SPS_P_SCK = 1;
    localparam int SPS_P_SS = 2;
    localparam int SPS_P_MISO = 3;
    localparam int SPS_P_SSLVL = 4;
    localparam logic [7:0] SPS_CTRL_RST = 8'h00;
    localparam logic [7:0] SPS_PINS_RST = 8'h00;
    // Clock divide per rate code 00..11
    localparam logic [7:0] SPS_SCK_DIV [4] = '{8'h04, 8'h10, 8'h40, 8'h80};
    localparam logic [3:0] SPS_BITS = 4'h8;
    typedef enum logic [2:0] {
        SPS_IDLE = 3'b001,
        SPS_MSHIFT = 3'b010,
        SPS_SSHIFT = 3'b100
    } sps_mode_t;
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] pins;
        logic done;
        logic write_collision_flag;
        logic arm_done;
        logic arm_write_collision_flag;
        sps_mode_t mode;
        logic [7:0] sh;
        logic [7:0] rx;
        logic [3:0] cnt;
        logic rxbit;
        logic [6:0] div;
        logic sck_m;
        logic sck_prev;
        logic ph_wr;
        logic [1:0] ph_idx;
        logic [31:0] hrdata;
        logic hready;
        logic hresp;
        logic irq;
        logic wake;
        logic mosi_o;
        logic mosi_oe;
        logic miso_o;
        logic miso_oe;
        logic sck_o;
        logic sck_oe;
        logic ss_o;
        logic ss_oe;
    } sps_state_t;
endpackage : sps_pkg

//--- verification/sps_slave_model.sv
// Behavioural serial slave that faces the port in its master role
`timescale 1ns/1ps
module sps_slave_model (
    input wire logic sck,
    input wire logic mosi,
    input wire logic ss_n,
    input wire logic pol,
    input wire logic pha,
    input wire logic lsb,
    input wire logic [7:0] tx_byte,
    output logic miso,
    output logic [7:0] rx_byte
);
    logic [7:0] sh = 8'h00;
    logic [7:0] rx = 8'h00;
    int cnt = 0;
    // High between leading and trailing clock edge
    wire lead = sck ^ pol;
    // Load on select so the first bit stands before the first edge
    always @(negedge ss_n) begin
        sh = tx_byte;
        cnt = 0;
    end
    // Sample edge and change edge follow the phase bit
    always @(lead) begin
        if (!ss_n) begin
            if (lead ^ pha) begin
                rx = lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
                cnt++;
            end else if (!pha || cnt != 0) begin
                sh = lsb ? {1'b0, sh[7:1]} : {sh[6:0], 1'b0};
            end
        end
    end
    // Deselected shows the inverse so a stale bit never passes
    assign miso = ss_n ^ (lsb ? sh[0] : sh[7]);
    assign rx_byte = rx;
endmodule : sps_slave_model

//--- verification/sps_top_tb.sv
// Register-level testbench for the serial port block
`timescale 1ns/1ps
module sps_top_tb;
    import sps_pkg::*;
    localparam logic [31:0] A_C = {SPS_ADDR_HI, SPS_IDX_CTRL, 2'b00};
    localparam logic [31:0] A_S = {SPS_ADDR_HI, SPS_IDX_STAT, 2'b00};
    localparam logic [31:0] A_D = {SPS_ADDR_HI, SPS_IDX_DATA, 2'b00};
    localparam logic [31:0] A_P = {SPS_ADDR_HI, SPS_IDX_PINS, 2'b00};
    logic hclk, hresetn, hwrite, gie, irq_ack, ss_drv, m_pol, m_pha, m_lsb, wake_seen, m_mosi;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic hreadyout, hresp, irq_o, wake_o;
    logic mosi_o, mosi_oe, miso_o, miso_oe, sck_o, sck_oe, ss_o, ss_oe, s_miso;
    logic [7:0] m_tx, m_rx, tx, ctrl, got;
    int err_count, check_count, cyc, t0, dt, n;
    // Wire levels resolved from the port's output enables
    wire mosi_w = mosi_oe ? mosi_o : m_mosi;
    wire sck_w = sck_oe ? sck_o : m_pol;
    wire miso_w = miso_oe ? miso_o : s_miso;
    wire ss_w = ss_oe ? ss_o : ss_drv;

    sps_top sps_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .gie_i(gie),
        .irq_ack_i(irq_ack), .irq_o(irq_o), .wake_o(wake_o), .mosi_i(mosi_w),
        .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_w), .miso_o(miso_o),
        .miso_oe(miso_oe), .sck_i(sck_w), .sck_o(sck_o), .sck_oe(sck_oe), .ss_i(ss_w),
        .ss_o(ss_o), .ss_oe(ss_oe));
    sps_slave_model sps_slave_model_i (.sck(sck_w), .mosi(mosi_w), .ss_n(ss_w),
        .pol(m_pol), .pha(m_pha), .lsb(m_lsb), .tx_byte(m_tx), .miso(s_miso),
        .rx_byte(m_rx));

    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    // Free cycle count and a sticky wake pulse catcher
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (wake_o === 1'b1) wake_seen <= 1'b1;
    end

    task automatic print_verdict;
        if (err_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : print_verdict
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // Waits for hready under a bound; a hang ends the run
    task automatic wait_rdy;
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        if (k >= 50) begin
            err_count++;
            print_verdict();
        end
    endtask : wait_rdy
    // One single word transfer: address phase, then data phase
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
        @(posedge hclk);
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask : ahb
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [31:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        check(rd, e);
    endtask : rdc

    initial begin
        {hresetn, htrans, haddr, hwrite, hwdata, gie, irq_ack} = '0;
        {m_pol, m_pha, m_lsb, m_tx, wake_seen, cyc, err_count, check_count, m_mosi, got} = '0;
        ss_drv = 1'b1;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        rdc(A_C, 32'h0);
        rdc(A_S, 32'h0);
        check({mosi_oe, miso_oe, sck_oe, ss_oe}, 32'h0);
        wr(A_C, 32'h2f);
        wr(32'h10, 32'hff); // Unmapped place ignores writes
        rdc(32'h10, 32'h0);
        rdc(A_C, 32'h2f);
        // Every clock mode, bit order and rate, last one with a collision
        for (int i = 0; i < 4; i++) begin
            m_pol <= i[1];
            m_pha <= i[0];
            m_lsb <= i[0] ^ i[1];
            m_tx <= 8'hc3 ^ 8'(i * 17);
            wr(A_P, 32'h17);
            ctrl = {2'b01, i[0] ^ i[1], 1'b1, i[1], i[0], i[1:0]};
            wr(A_C, {24'h0, ctrl});
            wr(A_P, 32'h07);
            tx = 8'h5a + 8'(i * 33);
            wr(A_D, {24'h0, tx});
            t0 = cyc;
            if (i == 3) wr(A_D, 32'hff);
            n = 0;
            do begin
                ahb(1'b0, A_S, 32'h0);
                n++;
            end while (rd[7] !== 1'b1 && n < 500);
            if (n >= 500) begin
                err_count++;
                print_verdict();
            end
            dt = cyc - t0;
            check(rd, i == 3 ? 32'hc0 : 32'h80);
            check(32'(dt >= 8 * SPS_SCK_DIV[i] && dt <= 8 * SPS_SCK_DIV[i] + 10), 1);
            rdc(A_D, {24'h0, m_tx});
            check({24'h0, m_rx}, {24'h0, tx});
            check({sck_oe, sck_o}, {30'h0, 1'b1, 1'(i[1])});
            check({miso_oe, mosi_oe}, 32'h1);
            rdc(A_S, 32'h0);
        end
        // Select pulled low while master: fault to slave
        gie <= 1'b1;
        wr(A_P, 32'h03);
        wr(A_C, 32'hd0);
        ss_drv <= 1'b0;
        repeat (3) @(posedge hclk);
        check(irq_o, 1);
        rdc(A_C, 32'hc0);
        check({mosi_oe, sck_oe}, 32'h0);
        ss_drv <= 1'b1;
        @(posedge hclk);
        irq_ack <= 1'b1;
        @(posedge hclk);
        irq_ack <= 1'b0;
        repeat (2) @(posedge hclk);
        check(irq_o, 0);
        rdc(A_S, 32'h0);
        rdc(A_C, 32'hc0);
        check(wake_seen, 0);
        // Bench acts as master on the pins while the port stays a slave
        m_pol <= 1'b0;
        wr(A_P, 32'h08);
        wr(A_D, 32'h96);
        tx = 8'h3c;
        ss_drv <= 1'b0;
        for (int b = 7; b >= 0; b--) begin
            m_mosi <= tx[b];
            repeat (4) @(posedge hclk);
            got[b] = miso_w;
            m_pol <= 1'b1;
            repeat (4) @(posedge hclk);
            m_pol <= 1'b0;
        end
        repeat (3) @(posedge hclk);
        check(wake_seen, 1);
        check(irq_o, 1);
        check({24'h0, got}, 32'h96);
        rdc(A_D, 32'h3c);
        print_verdict();
    end
endmodule : sps_top_tb
